// >>> include/brc_pkg.sv
/*
 * Shared constants and types for the bridge reset controller pair:
 * config register map, field positions, reset values, bus commands,
 * timing counts and state enumerations.
 * Assumes a single 25 MHz reference clock on both ends.
 */
package brc_pkg;
	// Device config register offsets and fields
	localparam logic [7:0] BRIDGE_CTL_OFS = 8'h3c;
	localparam logic [7:0] CHIP_CTL_OFS = 8'h40;
	localparam int BCTL_LSB = 16;
	localparam int SBR_BIT = 6;
	localparam int CHIP_RST_BIT = 0;
	localparam logic [15:0] BCTL_RST = 16'h0000;
	localparam logic [7:0] CCTL_RST = 8'h00;

	// Config commands on the byte-enable lines
	localparam logic [3:0] CMD_CFG_RD = 4'ha;
	localparam logic [3:0] CMD_CFG_WR = 4'hb;
	localparam logic [3:0] BE_ALL = 4'h0;

	// Timing
	localparam int CLK_FREQ_MHZ = 25;
	localparam int MAX_CLK_FREQ_MHZ = 66;
	localparam int SRST_REL_US = 100;
	localparam int SRST_REL_CYC = SRST_REL_US * CLK_FREQ_MHZ;
	localparam int REL_CNT_W = $clog2(SRST_REL_US * MAX_CLK_FREQ_MHZ + 1);
	localparam logic [REL_CNT_W-1:0] SRST_REL_LAST = REL_CNT_W'(SRST_REL_CYC - 1);
	localparam int CHIP_RST_MAX_CYC = 20;
	localparam int CHIP_CNT_W = 5;
	localparam logic [CHIP_CNT_W-1:0] CHIP_RST_HOLD = CHIP_CNT_W'(CHIP_RST_MAX_CYC - 4);
	localparam int ABORT_CYC = 8;
	localparam logic [3:0] ABORT_LAST = 4'(ABORT_CYC - 1);
	localparam int SEC_GNT_W = 4;

	// Host Avalon-MM word map and fields
	localparam logic [2:0] AV_CMD_IDX = 3'h0;
	localparam logic [2:0] AV_ADDR_IDX = 3'h1;
	localparam logic [2:0] AV_WDATA_IDX = 3'h2;
	localparam logic [2:0] AV_RDATA_IDX = 3'h3;
	localparam logic [2:0] AV_STATUS_IDX = 3'h4;
	localparam logic [2:0] AV_CTRL_IDX = 3'h5;
	localparam int CMD_GO_BIT = 0;
	localparam int CMD_WR_BIT = 1;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_ABORT_BIT = 1;
	localparam int ST_SRST_BIT = 2;
	localparam int CTL_PRST_BIT = 0;
	localparam int CTL_GNT_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;

	typedef enum logic [1:0] {T_IDLE, T_WAIT, T_ANS, T_REL} brc_tgt_t;
	typedef enum logic [2:0] {H_IDLE, H_PREP, H_ADDR, H_DATA, H_REL} brc_ini_t;
endpackage

// >>> include/brc_link_if.sv
/*
 * Primary-side link between the bridge reset controller and its host.
 * Resolves the shared three-state lines from each end's output enables;
 * undriven lines read as pulled high.
 */
`timescale 1ns/1ps
interface brc_link_if;
	logic prst_n;
	logic gnt_n;
	logic srst_n;
	logic frame_n_o;
	logic frame_n_oe;
	logic irdy_n_o;
	logic irdy_n_oe;
	logic [3:0] cbe_n_o;
	logic cbe_n_oe;
	logic [31:0] ad_h_o;
	logic ad_h_oe;
	logic [31:0] ad_d_o;
	logic ad_d_oe;
	logic trdy_n_o;
	logic trdy_n_oe;
	logic par_o;
	logic par_oe;
	logic frame_n;
	logic irdy_n;
	logic trdy_n;
	logic [3:0] cbe_n;
	logic [31:0] ad;
	logic par;

	// Wire levels, pull-ups where nobody drives
	assign frame_n = frame_n_oe ? frame_n_o : 1'b1;
	assign irdy_n = irdy_n_oe ? irdy_n_o : 1'b1;
	assign trdy_n = trdy_n_oe ? trdy_n_o : 1'b1;
	assign cbe_n = cbe_n_oe ? cbe_n_o : 4'hf;
	assign par = par_oe ? par_o : 1'b1;
	assign ad = ad_d_oe ? ad_d_o : (ad_h_oe ? ad_h_o : 32'hffffffff);

	modport dev (
		input prst_n, gnt_n, frame_n, irdy_n, cbe_n, ad,
		output srst_n, ad_d_o, ad_d_oe, trdy_n_o, trdy_n_oe, par_o, par_oe
	);
	modport host (
		input srst_n, trdy_n, ad, par,
		output prst_n, gnt_n, frame_n_o, frame_n_oe, irdy_n_o, irdy_n_oe,
		output cbe_n_o, cbe_n_oe, ad_h_o, ad_h_oe
	);
endinterface

// >>> rtl/brc_rst_sync.sv
/*
 * Reset synchroniser: asserts at once, releases on the second clock edge.
 * Assumes arst_n may change at any time relative to ref_clk.
 */
`timescale 1ns/1ps
module brc_rst_sync
	import brc_pkg::*;
(
	input logic ref_clk,
	input logic arst_n,
	input logic ce,
	output logic rst_n_sync
);
	typedef struct packed {
		logic meta;
		logic sync;
	} brc_sync_st_t;

	brc_sync_st_t st_q;
	brc_sync_st_t st_d;

	// Meta stage feeds only the second stage
	always_comb begin
		st_d = st_q;
		if (ce) begin
			st_d.meta = 1'b1;
			st_d.sync = st_q.meta;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rst_n_sync = st_q.sync;
endmodule // brc_rst_sync

// >>> rtl/brc_dev.sv
/*
 * Bridge reset controller, device end: config target for the bridge and
 * chip control registers, secondary reset timing, bus floating/parking,
 * and reset of buffers and core logic.
 * Assumes the host end on the link modport and the bridge core on the
 * user ports; everything runs on ref_clk.
 */
`timescale 1ns/1ps
// Operation
// - Hardware reset floats all pins, resets chip
// - Hardware reset restores register defaults
// - Hardware reset edges may be asynchronous
// - Hardware reset asserts secondary reset output
// - Bridge bit forces reset; release 100us later
// - Chip reset bit also sets bridge bit
// - Chip reset releases with bridge bit still set
// - Secondary reset holds until bridge bit written
// - Config access stays alive during secondary reset
// - Secondary reset floats secondary controls and grants
// - Secondary reset drives data, commands, parity low
// - Secondary reset clears posted and delayed buffers
// - No response during chip reset
// - Chip reset resets state, floats bus
// - Chip bit self-clears within 20 clocks
// - Names ending _n are active low
// - Sustained-tristate lines driven high before float
// - Park primary address/data when idle and granted
// - Address then data share multiplexed lines
// - Wake from hot state resets without secondary reset
// - Two reset sources: pin and chip bit
module brc_dev
	import brc_pkg::*;
(
	input logic ref_clk,
	input logic nrst,
	input logic ce,
	brc_link_if.dev link,
	input logic pm_wake,
	input logic [31:0] core_s_ad,
	input logic core_s_ad_oe,
	input logic [3:0] core_s_cbe_n,
	input logic core_secondary_parity,
	input logic [SEC_GNT_W-1:0] core_s_gnt_n,
	input logic core_s_frame_req,
	output logic core_rst_n,
	output logic buf_clear,
	output logic s_rst_n,
	output logic [31:0] s_ad_o,
	output logic s_ad_oe,
	output logic [3:0] s_cbe_n_o,
	output logic s_cbe_n_oe,
	output logic secondary_parity_o,
	output logic secondary_parity_oe,
	output logic [SEC_GNT_W-1:0] s_gnt_n_o,
	output logic [SEC_GNT_W-1:0] s_gnt_n_oe,
	output logic s_frame_n_o,
	output logic s_frame_n_oe
);
	typedef struct packed {
		brc_tgt_t tst;
		logic wr;
		logic [7:0] ofs;
		logic [31:0] ad;
		logic ad_oe;
		logic trdy_n;
		logic trdy_oe;
		logic par;
		logic par_oe;
		logic [15:0] bctl;
		logic [7:0] cctl;
		logic [CHIP_CNT_W-1:0] chip_cnt;
		logic srst;
		logic [REL_CNT_W-1:0] rel_cnt;
		logic wake;
		logic [31:0] sad;
		logic [3:0] scbe;
		logic spar;
		logic sad_oe;
		logic [SEC_GNT_W-1:0] sgnt;
		logic sfr;
		logic sfr_oe;
	} brc_dev_st_t;

	// Secondary reset starts asserted so the bus sees a full 100us release
	localparam brc_dev_st_t DEV_RST = '{
		tst: T_IDLE,
		trdy_n: 1'b1,
		bctl: BCTL_RST,
		cctl: CCTL_RST,
		srst: 1'b1,
		sgnt: '1,
		sfr: 1'b1,
		default: '0
	};

	brc_dev_st_t st_q;
	brc_dev_st_t st_d;
	logic arst_n;
	logic rst_n_sync;
	logic chip_busy;
	logic park;
	logic sbr;
	logic s_reset;
	logic pri_live;
	logic sec_live;
	logic [1:0] hit;

	// Decode of the two config words: {chip, bridge}
	function automatic logic [1:0] reg_hit(input logic [7:0] ofs);
		return {ofs == CHIP_CTL_OFS, ofs == BRIDGE_CTL_OFS};
	endfunction

	// Either reset source clears the whole device; release is synchronised
	assign arst_n = nrst & link.prst_n;

	brc_rst_sync u_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.ce(ce),
		.rst_n_sync(rst_n_sync)
	);

	assign chip_busy = st_q.chip_cnt != '0;
	assign sbr = st_q.bctl[SBR_BIT];
	assign park = !link.gnt_n && link.frame_n && link.irdy_n;
	assign hit = reg_hit(st_q.ofs);

	// Next state
	always_comb begin
		st_d = st_q;
		if (ce) begin
			st_d.wake = pm_wake;
			// Wake restores defaults but leaves the secondary reset alone
			if (pm_wake) begin
				st_d.bctl = BCTL_RST;
				st_d.cctl = CCTL_RST;
			end
			if (chip_busy) begin
				st_d.chip_cnt = st_q.chip_cnt - 1'b1;
			end

			// Release timer runs only once the bridge bit is clear
			if (sbr) begin
				st_d.srst = 1'b1;
				st_d.rel_cnt = '0;
			end else if (st_q.srst) begin
				if (st_q.rel_cnt == SRST_REL_LAST) begin
					st_d.srst = 1'b0;
				end else begin
					st_d.rel_cnt = st_q.rel_cnt + 1'b1;
				end
			end

			// Parity follows the address/data lines by one cycle
			st_d.par = ^{link.ad, link.cbe_n};
			st_d.par_oe = st_q.ad_oe;

			// Config target
			case (st_q.tst)
				T_IDLE: begin
					st_d.trdy_oe = 1'b0;
					st_d.ad = '0;
					st_d.ad_oe = park;
					if (!link.frame_n && (link.cbe_n == CMD_CFG_RD || link.cbe_n == CMD_CFG_WR)) begin
						st_d.ofs = link.ad[7:0];
						st_d.wr = link.cbe_n == CMD_CFG_WR;
						st_d.ad_oe = 1'b0;
						st_d.tst = T_WAIT;
					end
				end
				T_WAIT: begin
					if (link.frame_n && link.irdy_n) begin
						st_d.tst = T_IDLE;
					end else if (!link.irdy_n && !chip_busy) begin
						st_d.trdy_n = 1'b0;
						st_d.trdy_oe = 1'b1;
						st_d.tst = T_ANS;
						if (st_q.wr) begin
							if (hit[0]) begin
								st_d.bctl = link.ad[BCTL_LSB +: 16];
							end
							if (hit[1]) begin
								st_d.cctl = link.ad[7:0];
								if (link.ad[CHIP_RST_BIT]) begin
									st_d.bctl[SBR_BIT] = 1'b1;
								end
							end
						end else begin
							st_d.ad = ({32{hit[0]}} & {st_q.bctl, 16'h0000}) |
								({32{hit[1]}} & {24'h000000, st_q.cctl});
							st_d.ad_oe = 1'b1;
						end
					end
				end
				T_ANS: begin
					st_d.trdy_n = 1'b1;
					st_d.ad_oe = 1'b0;
					st_d.tst = T_REL;
				end
				T_REL: begin
					st_d.trdy_oe = 1'b0;
					st_d.tst = T_IDLE;
					// Chip reset starts once its own write has completed
					if (st_q.cctl[CHIP_RST_BIT]) begin
						st_d = DEV_RST;
						st_d.bctl[SBR_BIT] = 1'b1;
						st_d.chip_cnt = CHIP_RST_HOLD;
					end
				end
				default: begin
					st_d.tst = T_IDLE;
				end
			endcase

			// Secondary outputs from the core, registered
			st_d.sad = core_s_ad;
			st_d.scbe = core_s_cbe_n;
			st_d.spar = core_secondary_parity;
			st_d.sad_oe = core_s_ad_oe;
			st_d.sgnt = core_s_gnt_n;
			if (core_s_frame_req && !s_reset) begin
				st_d.sfr = 1'b0;
				st_d.sfr_oe = 1'b1;
			end else if (st_q.sfr_oe && !st_q.sfr && !s_reset) begin
				st_d.sfr = 1'b1;
			end else begin
				st_d.sfr = 1'b1;
				st_d.sfr_oe = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			st_q <= DEV_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Pin enables gated straight from the reset pin, no clock needed
	assign pri_live = link.prst_n & ~chip_busy;
	assign sec_live = link.prst_n & ~chip_busy;
	assign s_reset = st_q.srst | sbr;
	assign s_rst_n = link.prst_n & ~s_reset;
	assign link.srst_n = s_rst_n;

	assign link.ad_d_o = st_q.ad;
	assign link.ad_d_oe = pri_live & st_q.ad_oe;
	assign link.trdy_n_o = st_q.trdy_n;
	assign link.trdy_n_oe = pri_live & st_q.trdy_oe;
	assign link.par_o = st_q.par;
	assign link.par_oe = pri_live & st_q.par_oe;

	// Secondary data lines held low during secondary reset, but floated while the reset pin is low or chip reset runs
	assign s_ad_o = s_reset ? 32'h00000000 : st_q.sad;
	assign s_ad_oe = sec_live & (s_reset | st_q.sad_oe);
	assign s_cbe_n_o = s_reset ? 4'h0 : st_q.scbe;
	assign s_cbe_n_oe = sec_live & (s_reset | st_q.sad_oe);
	assign secondary_parity_o = s_reset ? 1'b0 : st_q.spar;
	assign secondary_parity_oe = sec_live & (s_reset | st_q.sad_oe);
	assign s_gnt_n_o = st_q.sgnt;
	assign s_frame_n_o = st_q.sfr;
	assign s_frame_n_oe = sec_live & ~s_reset & st_q.sfr_oe;

	// Each grant floats at once on secondary reset
	genvar g;
	generate
		for (g = 0; g < SEC_GNT_W; g++) begin : g_gnt
			assign s_gnt_n_oe[g] = sec_live & ~s_reset;
		end
	endgenerate

	// Buffers held clear while any reset is in force
	assign buf_clear = s_reset | chip_busy | st_q.wake | ~rst_n_sync;
	assign core_rst_n = rst_n_sync & ~chip_busy & ~st_q.wake;
endmodule // brc_dev

// >>> rtl/brc_host.sv
/*
 * Bridge reset controller, host end: Avalon-MM slave registers that
 * launch single config reads/writes over the primary link, drive the
 * primary reset and grant, and report status.
 * Assumes the device end on the link modport; one clock.
 */
`timescale 1ns/1ps
module brc_host
	import brc_pkg::*;
(
	input logic ref_clk,
	input logic nrst,
	input logic ce,
	input logic [2:0] avs_address,
	input logic avs_read,
	input logic avs_write,
	input logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	brc_link_if.host link
);
	typedef struct packed {
		brc_ini_t hst;
		logic wr;
		logic abort;
		logic [1:0] ctrl;
		logic [3:0] cnt;
		logic ack;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [31:0] rd;
		logic frame_n;
		logic frame_oe;
		logic irdy_n;
		logic irdy_oe;
		logic [31:0] ad;
		logic ad_oe;
		logic [3:0] cbe;
		logic cbe_oe;
	} brc_host_st_t;

	localparam brc_host_st_t HOST_RST = '{
		hst: H_IDLE,
		ctrl: CTRL_RST,
		frame_n: 1'b1,
		irdy_n: 1'b1,
		cbe: 4'hf,
		default: '0
	};

	brc_host_st_t st_q;
	brc_host_st_t st_d;
	logic busy;

	assign busy = st_q.hst != H_IDLE;

	always_comb begin
		st_d = st_q;
		if (ce) begin
			// Initiator: address phase, then one data phase
			case (st_q.hst)
				H_IDLE: begin
				end
				H_PREP: begin
					st_d.frame_n = 1'b0;
					st_d.frame_oe = 1'b1;
					st_d.ad = st_q.addr;
					st_d.ad_oe = 1'b1;
					st_d.cbe = st_q.wr ? CMD_CFG_WR : CMD_CFG_RD;
					st_d.cbe_oe = 1'b1;
					st_d.hst = H_ADDR;
				end
				H_ADDR: begin
					st_d.frame_n = 1'b1;
					st_d.irdy_n = 1'b0;
					st_d.irdy_oe = 1'b1;
					st_d.ad = st_q.wdata;
					st_d.ad_oe = st_q.wr;
					st_d.cbe = BE_ALL;
					st_d.cnt = '0;
					st_d.hst = H_DATA;
				end
				H_DATA: begin
					st_d.frame_oe = 1'b0;
					if (!link.trdy_n || st_q.cnt == ABORT_LAST) begin
						st_d.abort = link.trdy_n;
						if (!st_q.wr) begin
							st_d.rdata = link.ad;
						end
						st_d.irdy_n = 1'b1;
						st_d.ad_oe = 1'b0;
						st_d.cbe_oe = 1'b0;
						st_d.cbe = 4'hf;
						st_d.hst = H_REL;
					end else begin
						st_d.cnt = st_q.cnt + 1'b1;
					end
				end
				H_REL: begin
					st_d.irdy_oe = 1'b0;
					st_d.hst = H_IDLE;
				end
				default: begin
					st_d.hst = H_IDLE;
				end
			endcase

			// Avalon slave: one wait cycle, then answer
			if ((avs_read || avs_write) && !st_q.ack) begin
				st_d.ack = 1'b1;
				case (avs_address)
					AV_CMD_IDX: st_d.rd = {30'h00000000, st_q.wr, busy};
					AV_ADDR_IDX: st_d.rd = st_q.addr;
					AV_WDATA_IDX: st_d.rd = st_q.wdata;
					AV_RDATA_IDX: st_d.rd = st_q.rdata;
					AV_STATUS_IDX: st_d.rd = {29'h00000000, ~link.srst_n, st_q.abort, busy};
					AV_CTRL_IDX: st_d.rd = {30'h00000000, st_q.ctrl};
					default: st_d.rd = '0;
				endcase
			end else begin
				st_d.ack = 1'b0;
			end
			if (avs_write && st_q.ack) begin
				case (avs_address)
					AV_CMD_IDX: begin
						// A new command while busy is ignored
						if (!busy && avs_writedata[CMD_GO_BIT]) begin
							st_d.wr = avs_writedata[CMD_WR_BIT];
							st_d.abort = 1'b0;
							st_d.hst = H_PREP;
						end
					end
					AV_ADDR_IDX: st_d.addr = avs_writedata;
					AV_WDATA_IDX: st_d.wdata = avs_writedata;
					AV_CTRL_IDX: st_d.ctrl = avs_writedata[1:0];
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= HOST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
	assign avs_readdata = st_q.rd;

	// Primary reset follows host reset or the control bit
	assign link.prst_n = nrst & ~st_q.ctrl[CTL_PRST_BIT];
	// Grant drops a cycle before any address phase so parking stops
	assign link.gnt_n = ~(st_q.ctrl[CTL_GNT_BIT] & (st_q.hst == H_IDLE));
	assign link.frame_n_o = st_q.frame_n;
	assign link.frame_n_oe = st_q.frame_oe;
	assign link.irdy_n_o = st_q.irdy_n;
	assign link.irdy_n_oe = st_q.irdy_oe;
	assign link.cbe_n_o = st_q.cbe;
	assign link.cbe_n_oe = st_q.cbe_oe;
	assign link.ad_h_o = st_q.ad;
	assign link.ad_h_oe = st_q.ad_oe;
endmodule // brc_host

// >>> verif/brc_link_monitor.sv
/* Checker for the primary link between the host and device ends.
   Assumes the resolved link signals, one clock and the bench reset. */
`timescale 1ns/1ps
module brc_link_monitor
	import brc_pkg::*;
(
	input logic ref_clk,
	input logic nrst,
	input logic prst_n,
	input logic gnt_n,
	input logic srst_n,
	input logic frame_n,
	input logic frame_n_oe,
	input logic irdy_n,
	input logic trdy_n,
	input logic trdy_n_oe,
	input logic [3:0] cbe_n,
	input logic [31:0] ad,
	input logic ad_h_oe,
	input logic ad_d_oe,
	input logic par,
	input logic par_oe
);
	localparam int REL_MIN = 2497;
	logic [2:0] up_q;
	logic [11:0] low_q;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// Time since primary reset left, and length of each secondary reset
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			up_q <= 3'h0;
			low_q <= 12'h000;
		end else begin
			up_q <= !prst_n ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
			low_q <= srst_n ? 12'h000 : low_q + {11'h000, low_q != 12'hfff};
		end
	end
	sequence s_rd_addr;
		$fell(frame_n) && cbe_n == CMD_CFG_RD;
	endsequence
	sequence s_wr_addr;
		$fell(frame_n) && cbe_n == CMD_CFG_WR;
	endsequence
	// Parking only once the synchroniser has let the device go
	sequence s_idle_gnt;
		up_q == 3'h7 && !gnt_n && frame_n && irdy_n;
	endsequence
	a_prst_srst: assert property (!prst_n |-> !srst_n)
		else $error("secondary reset not held by primary reset");
	a_prst_float: assert property (!prst_n |-> !ad_d_oe && !trdy_n_oe && !par_oe)
		else $error("device drives link during primary reset");
	a_trdy_release: assert property ($fell(trdy_n) |=> trdy_n ##1 !trdy_n_oe)
		else $error("target ready not released high then floated");
	a_frame_release: assert property ($rose(frame_n) && frame_n_oe |=> !frame_n_oe)
		else $error("frame not floated after one high cycle");
	a_park_ad: assert property (s_idle_gnt |=> ad_d_oe && ad == 32'h0)
		else $error("idle granted bus not parked");
	a_par_value: assert property (par_oe |-> par == ^{$past(ad), $past(cbe_n)})
		else $error("parity wrong for previous cycle");
	a_addr_host: assert property ($fell(frame_n) |-> frame_n_oe && ad_h_oe && !ad_d_oe)
		else $error("address phase not driven by initiator");
	a_read_target: assert property (s_rd_addr ##2 !trdy_n |-> ad_d_oe)
		else $error("read data not driven by target");
	a_write_init: assert property (s_wr_addr |=> ad_h_oe && !ad_d_oe && !irdy_n)
		else $error("write data not driven by initiator");
	a_srst_hold: assert property ($rose(srst_n) |-> low_q >= REL_MIN)
		else $error("secondary reset released early");
endmodule // brc_link_monitor

// >>> verif/pci_bridge_reset_control_tb.sv
/* Bench for the joined host and device ends of the reset controller.
   Assumes the package map; drives Avalon, core and wake inputs. */
`timescale 1ns/1ps
module pci_bridge_reset_control_tb
	import brc_pkg::*;
;
	localparam logic [31:0] SBR_MASK = 32'h1 << (BCTL_LSB + SBR_BIT);
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd, st, s_ad_o;
	logic avs_waitrequest, core_rst_n, buf_clear, s_rst_n, s_ad_oe, s_cbe_n_oe, secondary_parity_o, secondary_parity_oe;
	logic s_frame_n_o, s_frame_n_oe;
	logic pm_wake = 1'b0;
	logic [31:0] core_s_ad = 32'h5a5ac3c3;
	logic core_s_ad_oe = 1'b1;
	logic [3:0] core_s_cbe_n = 4'h6;
	logic [3:0] s_cbe_n_o;
	logic core_secondary_parity = 1'b1;
	logic core_s_frame_req = 1'b1;
	logic [SEC_GNT_W-1:0] core_s_gnt_n = SEC_GNT_W'(4'ha);
	logic [SEC_GNT_W-1:0] s_gnt_n_o, s_gnt_n_oe;
	int miscompares = 0;
	int cmp_count = 0;
	int cyc = 0;
	int land_cyc = 0;
	int n;

	brc_link_if brc_link_if_i();
	brc_dev brc_dev_i (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .link(brc_link_if_i.dev), .pm_wake(pm_wake),
		.core_s_ad(core_s_ad), .core_s_ad_oe(core_s_ad_oe), .core_s_cbe_n(core_s_cbe_n), .core_secondary_parity(core_secondary_parity),
		.core_s_gnt_n(core_s_gnt_n), .core_s_frame_req(core_s_frame_req), .core_rst_n(core_rst_n),
		.buf_clear(buf_clear), .s_rst_n(s_rst_n), .s_ad_o(s_ad_o), .s_ad_oe(s_ad_oe), .s_cbe_n_o(s_cbe_n_o),
		.s_cbe_n_oe(s_cbe_n_oe), .secondary_parity_o(secondary_parity_o), .secondary_parity_oe(secondary_parity_oe), .s_gnt_n_o(s_gnt_n_o),
		.s_gnt_n_oe(s_gnt_n_oe), .s_frame_n_o(s_frame_n_o), .s_frame_n_oe(s_frame_n_oe));
	brc_host brc_host_i (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link(brc_link_if_i.host));
	brc_link_monitor brc_link_monitor_i (.ref_clk(ref_clk), .nrst(nrst), .prst_n(brc_link_if_i.prst_n),
		.gnt_n(brc_link_if_i.gnt_n), .srst_n(brc_link_if_i.srst_n), .frame_n(brc_link_if_i.frame_n),
		.frame_n_oe(brc_link_if_i.frame_n_oe), .irdy_n(brc_link_if_i.irdy_n), .trdy_n(brc_link_if_i.trdy_n),
		.trdy_n_oe(brc_link_if_i.trdy_n_oe), .cbe_n(brc_link_if_i.cbe_n), .ad(brc_link_if_i.ad),
		.ad_h_oe(brc_link_if_i.ad_h_oe), .ad_d_oe(brc_link_if_i.ad_d_oe), .par(brc_link_if_i.par),
		.par_oe(brc_link_if_i.par_oe));

	always #20 ref_clk = ~ref_clk;
	// Cycle count; last edge at which the target answered
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (brc_link_if_i.trdy_n === 1'b0) land_cyc <= cyc;
	end
	// Comparisons, one per kind of result
	task automatic chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One Avalon word; entered just after a rising edge, leaves one edge after the answer edge
	task automatic av(input logic wr, input logic [2:0] idx, input logic [31:0] wdata, output logic [31:0] rdata);
		int k;
		k = 0;
		avs_address <= idx;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wdata;
		@(negedge ref_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(negedge ref_clk);
			k++;
		end
		// Answer edge: waitrequest low here, read data taken here
		@(posedge ref_clk);
		rdata = avs_readdata;
		chk1(k == 1, 1'b1);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// Idle edge, so a following call never re-raises a strobe in this time step
		@(posedge ref_clk);
	endtask
	// Launch, then poll busy with a bound; a hang shows as busy still set
	task automatic go(input logic wr);
		av(1'b1, AV_CMD_IDX, (32'(wr) << CMD_WR_BIT) | (32'h1 << CMD_GO_BIT), rd);
	endtask
	task automatic poll(output logic [31:0] s);
		int k;
		k = 0;
		do begin
			av(1'b0, AV_STATUS_IDX, 32'h0, s);
			k++;
		end while (s[ST_BUSY_BIT] !== 1'b0 && k < 40);
		chk1(s[ST_BUSY_BIT], 1'b0);
	endtask
	task automatic cfg(input logic wr, input logic [7:0] ofs, input logic [31:0] wdata, output logic [31:0] r);
		av(1'b1, AV_ADDR_IDX, {24'h0, ofs}, r);
		av(1'b1, AV_WDATA_IDX, wdata, r);
		go(wr);
		poll(st);
		av(1'b0, AV_RDATA_IDX, 32'h0, r);
	endtask
	task automatic wait_srst(input int lim, output int cnt);
		cnt = 0;
		while (s_rst_n !== 1'b1 && cnt < lim) begin
			@(negedge ref_clk);
			cnt++;
		end
		@(posedge ref_clk);
	endtask
	// Secondary side held in reset
	task automatic chk_sec_reset();
		chk32(s_ad_o, 32'h0);
		chk1(s_cbe_n_o === 4'h0 && secondary_parity_o === 1'b0, 1'b1);
		chk1(|{s_gnt_n_oe, s_frame_n_oe}, 1'b0);
		chk1(buf_clear, 1'b1);
	endtask
	task automatic test_hw_reset();
		repeat (8) @(negedge ref_clk);
		chk1(brc_link_if_i.srst_n, 1'b0);
		chk1(core_rst_n | brc_link_if_i.ad_d_oe | brc_link_if_i.trdy_n_oe, 1'b0);
		chk_sec_reset();
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		wait_srst(3000, n);
		chk1(n > 2490 && n < 2510, 1'b1);
		cfg(1'b0, BRIDGE_CTL_OFS, 32'h0, rd);
		chk32(rd, {BCTL_RST, 16'h0});
		cfg(1'b0, CHIP_CTL_OFS, 32'h0, rd);
		chk32(rd, {24'h0, CCTL_RST});
		$display("test_hw_reset done");
	endtask
	task automatic test_park();
		av(1'b1, AV_CTRL_IDX, 32'h1 << CTL_GNT_BIT, rd);
		repeat (3) @(negedge ref_clk);
		chk32(brc_link_if_i.ad, 32'h0);
		chk1(brc_link_if_i.ad_d_oe & brc_link_if_i.par_oe, 1'b1);
		@(posedge ref_clk);
		av(1'b1, AV_CTRL_IDX, 32'h0, rd);
		repeat (2) @(negedge ref_clk);
		chk1(brc_link_if_i.ad_d_oe, 1'b0);
		@(posedge ref_clk);
		$display("test_park done");
	endtask
	task automatic test_wake();
		cfg(1'b1, CHIP_CTL_OFS, 32'h5a, rd);
		cfg(1'b0, CHIP_CTL_OFS, 32'h0, rd);
		chk32(rd, 32'h5a);
		pm_wake <= 1'b1;
		@(posedge ref_clk);
		pm_wake <= 1'b0;
		n = 0;
		repeat (4) begin
			@(negedge ref_clk);
			n += int'(core_rst_n === 1'b0);
			chk1(s_rst_n, 1'b1);
		end
		chk1(n > 0, 1'b1);
		@(posedge ref_clk);
		cfg(1'b0, CHIP_CTL_OFS, 32'h0, rd);
		chk32(rd, {24'h0, CCTL_RST});
		$display("test_wake done");
	endtask
	task automatic test_sbr();
		cfg(1'b1, BRIDGE_CTL_OFS, SBR_MASK, rd);
		@(negedge ref_clk);
		chk1(s_rst_n, 1'b0);
		chk_sec_reset();
		chk1(s_ad_oe & s_cbe_n_oe & secondary_parity_oe, 1'b1);
		@(posedge ref_clk);
		cfg(1'b0, BRIDGE_CTL_OFS, 32'h0, rd);
		chk32(rd, SBR_MASK);
		chk1(st[ST_SRST_BIT], 1'b1);
		cfg(1'b1, BRIDGE_CTL_OFS, 32'h0, rd);
		// Clock enable low freezes the release timer for ten edges
		ce <= 1'b0;
		repeat (10) @(posedge ref_clk);
		ce <= 1'b1;
		wait_srst(3000, n);
		chk1((cyc - land_cyc) inside {[2507:2513]}, 1'b1);
		repeat (2) @(negedge ref_clk);
		chk32(s_ad_o, core_s_ad);
		chk1(s_ad_oe & (s_gnt_n_oe === 4'hf) & (s_gnt_n_o === core_s_gnt_n), 1'b1);
		chk1(buf_clear, 1'b0);
		chk1(s_cbe_n_o === core_s_cbe_n && secondary_parity_o === core_secondary_parity && s_frame_n_oe && !s_frame_n_o, 1'b1);
		@(posedge ref_clk);
		// Frame request dropped: driven high one cycle, then floated
		core_s_frame_req <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk1(s_frame_n_o & s_frame_n_oe, 1'b1);
		@(negedge ref_clk);
		chk1(s_frame_n_oe, 1'b0);
		@(posedge ref_clk);
		core_s_frame_req <= 1'b1;
		$display("test_sbr done");
	endtask
	task automatic test_prst();
		cfg(1'b1, CHIP_CTL_OFS, 32'h5a, rd);
		av(1'b1, AV_CTRL_IDX, 32'h1 << CTL_PRST_BIT, rd);
		@(negedge ref_clk);
		chk1(brc_link_if_i.srst_n | brc_link_if_i.ad_d_oe | core_rst_n, 1'b0);
		chk_sec_reset();
		@(posedge ref_clk);
		av(1'b1, AV_CTRL_IDX, 32'h0, rd);
		repeat (4) @(posedge ref_clk);
		cfg(1'b0, CHIP_CTL_OFS, 32'h0, rd);
		chk32(rd, {24'h0, CCTL_RST});
		wait_srst(3000, n);
		chk1(n > 2400 && n < 3000, 1'b1);
		$display("test_prst done");
	endtask
	// Chip reset; a read launched at once must go unanswered
	task automatic test_chip();
		av(1'b1, AV_ADDR_IDX, {24'h0, CHIP_CTL_OFS}, rd);
		av(1'b1, AV_WDATA_IDX, 32'h1 << CHIP_RST_BIT, rd);
		// Read launched right after busy drops, timing out just as the refusal window closes
		go(1'b1);
		poll(st);
		go(1'b0);
		@(negedge ref_clk);
		chk1(s_rst_n | core_rst_n | brc_link_if_i.trdy_n_oe, 1'b0);
		chk_sec_reset();
		@(posedge ref_clk);
		poll(st);
		chk1(st[ST_ABORT_BIT], 1'b1);
		cfg(1'b0, CHIP_CTL_OFS, 32'h0, rd);
		chk32(rd, 32'h0);
		cfg(1'b0, BRIDGE_CTL_OFS, 32'h0, rd);
		chk32(rd, SBR_MASK);
		repeat (2600) @(negedge ref_clk);
		chk1(s_rst_n, 1'b0);
		@(posedge ref_clk);
		cfg(1'b1, BRIDGE_CTL_OFS, 32'h0, rd);
		wait_srst(2600, n);
		chk1(n < 2600, 1'b1);
		$display("test_chip done");
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		test_hw_reset();
		test_park();
		test_wake();
		test_sbr();
		test_prst();
		test_chip();
		finish_test();
	end
	// Watchdog, well past the expected run of about 13000 cycles
	initial begin
		repeat (40000) @(posedge ref_clk);
		miscompares++;
		finish_test();
	end
endmodule // pci_bridge_reset_control_tb
